// [core/fbs_fifo.sv]
// Purpose: Received process data buffer
// Assumes: Single clock, synchronous reset
// Notes:   Depth must be a power of two
`timescale 1ns/1ps
module fbs_fifo #(
   parameter int W = 33,
   parameter int D = 16
) (
   input  wire logic         mclk,
   input  wire logic         reset,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   initial begin
      if (D < 2 || (D & (D - 1)) != 0) $error("fbs_fifo depth must be a power of two");
   end
   logic [W-1:0] mem_q [D];
   logic [AW:0]  wp_q;
   logic [AW:0]  rp_q;
   logic         push;
   logic         pop;
   assign in_ready  = (wp_q - rp_q) != (AW + 1)'(D);
   assign out_valid = wp_q != rp_q;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_q[rp_q[AW-1:0]];
   always_ff @(posedge mclk) begin
      if (push) begin
         mem_q[wp_q[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop) rp_q <= rp_q + 1'b1;
      end
   end
endmodule

// [core/fbs_link_if.sv]
// Purpose: Frame link between bus master and drive slave
// Assumes: Both ends on mclk
// Notes:   Return path carries frames back to the master
`timescale 1ns/1ps
interface fbs_link_if;
   import fbs_pkg::*;
   logic       m2s_valid;
   fbs_frame_s m2s_frm;
   logic       s2m_valid;
   fbs_frame_s s2m_frm;
   logic       sync0;
   modport master (output m2s_valid, output m2s_frm, output sync0, input s2m_valid, input s2m_frm);
   modport slave  (input m2s_valid, input m2s_frm, input sync0, output s2m_valid, output s2m_frm);
endinterface

// [core/fbs_master.sv]
// Purpose: Bus master end: frame issue, stepwise state requests, sync event
// Assumes: One frame in flight at a time
// Notes:   Sync is held back while a frame is outstanding
`timescale 1ns/1ps
module fbs_master #(
   parameter int SYNC_CYCLES = fbs_pkg::SYNC_CYC
) (
   input  wire logic           mclk,
   input  wire logic           reset,
   fbs_link_if.master          link,
   input  wire logic           cmd_valid,
   output logic                cmd_ready,
   input  wire fbs_pkg::fbs_frame_s cmd_frm,
   output logic                rsp_valid,
   output fbs_pkg::fbs_frame_s rsp_frm,
   input  wire logic           dc_enable,
   output fbs_pkg::fbs_state_e cur_state
);
   import fbs_pkg::*;
   initial begin
      if (SYNC_CYCLES < 4) $error("fbs_master sync period too short");
   end
   typedef enum logic [1:0] {FBSM_IDLE, FBSM_SEND, FBSM_WAIT} fbsm_st_e;
   fbsm_st_e    st_q;
   fbs_frame_s  frm_q;
   logic [1:0]  goal_q;
   logic [31:0] cnt_q;
   logic        spend_q;
   logic        sync_q;
   logic [1:0]  cur_n;
   logic [1:0]  step;
   assign cur_n = cur_state;
   assign step  = (goal_q > cur_n + 2'h1) ? cur_n + 2'h1 : goal_q;
   assign cmd_ready = st_q == FBSM_IDLE && !spend_q;
   always_ff @(posedge mclk) begin
      if (reset) begin
         st_q      <= FBSM_IDLE;
         frm_q     <= '0;
         goal_q    <= 2'h0;
         rsp_valid <= 1'b0;
         rsp_frm   <= '0;
         cur_state <= FBS_INIT;
      end else begin
         rsp_valid <= 1'b0;
         case (st_q)
            FBSM_IDLE: begin
               if (cmd_valid && cmd_ready) begin
                  frm_q  <= cmd_frm;
                  goal_q <= cmd_frm.data[1:0];
                  st_q   <= FBSM_SEND;
               end
            end
            FBSM_SEND: begin
               if (frm_q.cmd == CMD_STATE) frm_q.data <= {30'h00000000, step}; // [R11]
               st_q <= FBSM_WAIT;
            end
            FBSM_WAIT: begin
               if (link.s2m_valid) begin
                  if (frm_q.cmd == CMD_STATE && link.s2m_frm.wkc && !link.s2m_frm.err) begin
                     cur_state <= fbs_state_e'(link.s2m_frm.data[1:0]);
                  end
                  if (frm_q.cmd == CMD_STATE && !link.s2m_frm.err &&
                      link.s2m_frm.data[1:0] != goal_q) begin
                     st_q <= FBSM_SEND; // [R11]
                  end else begin
                     rsp_valid <= 1'b1;
                     rsp_frm   <= link.s2m_frm;
                     st_q      <= FBSM_IDLE;
                  end
               end
            end
            default: st_q <= FBSM_IDLE;
         endcase
      end
   end
   // The master alone originates frames; one per request, or one per step of a state request
   assign link.m2s_valid = st_q == FBSM_SEND; // [R6]
   always_comb begin
      link.m2s_frm = frm_q;
      if (frm_q.cmd == CMD_STATE) link.m2s_frm.data = {30'h00000000, step};
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         cnt_q   <= 32'h00000000;
         spend_q <= 1'b0;
         sync_q  <= 1'b0;
      end else begin
         sync_q <= 1'b0;
         cnt_q  <= (cnt_q == 32'(SYNC_CYCLES - 1)) ? 32'h00000000 : cnt_q + 32'h00000001;
         if (cnt_q == 32'(SYNC_CYCLES - 1) && dc_enable) spend_q <= 1'b1;
         else if (spend_q && st_q == FBSM_IDLE) begin
            spend_q <= 1'b0; // [R10]
            sync_q  <= 1'b1;
         end
      end
   end
   assign link.sync0 = sync_q;
endmodule

// [core/fbs_pkg.sv]
// Purpose: Shared types and constants of the fieldbus slave communication block
// Assumes: One clock, mclk at 40 MHz
// Notes:   Frame words model one datagram each
package fbs_pkg;
   typedef enum logic [1:0] {FBS_INIT, FBS_PREOP, FBS_SAFEOP, FBS_OP} fbs_state_e;
   typedef enum logic [2:0] {CMD_NOP, CMD_STATE, CMD_SDO_WR, CMD_SDO_RD,
                             CMD_RXPDO, CMD_TXPDO, CMD_ASSIGN} fbs_cmd_e;
   typedef struct packed {
      fbs_cmd_e    cmd;
      logic [15:0] adr;
      logic [15:0] idx;
      logic [7:0]  sub;
      logic [31:0] data;
      logic        err;
      logic        wkc;
   } fbs_frame_s;
   localparam logic [15:0] IDX_STN_VAL   = 16'h2023;
   localparam logic [15:0] IDX_STN_SRC   = 16'h2024;
   localparam logic [15:0] IDX_OVSPD     = 16'h2513;
   localparam logic [15:0] IDX_SYNC_MODE = 16'h2f00;
   localparam logic [15:0] IDX_RXMAP0    = 16'h1600;
   localparam logic [15:0] IDX_RXMAP1    = 16'h1601;
   localparam logic [15:0] IDX_TXMAP0    = 16'h1a00;
   localparam logic [15:0] IDX_TXMAP1    = 16'h1a01;
   localparam logic [15:0] RST_STN_VAL   = 16'h0002;
   localparam logic [15:0] RST_STN_SRC   = 16'h0001;
   localparam logic [15:0] RST_OVSPD     = 16'h0000;
   localparam logic [15:0] STN_VAL_MAX   = 16'h7fff;
   localparam logic [15:0] STN_SRC_MAX   = 16'h0001;
   localparam logic [15:0] OVSPD_MAX     = 16'h2710;
   localparam logic [18:0] OVS_NUM       = 19'h00006;
   localparam logic [18:0] OVS_DEN       = 19'h00005;
   localparam logic [3:0]  MAP_MAX_ENT   = 4'h8;
   localparam logic [8:0]  MAP_MAX_BITS  = 9'h100;
   localparam int          MAP_LEN_LSB   = 0;
   localparam int          PDO_SETS      = 2;
   localparam int          RX_FIFO_DEPTH = 16;
   localparam int          CLK_HZ        = 40000000;
   localparam int          SYNC_PERIOD_US = 1000;
   localparam int          SYNC_CYC      = CLK_HZ / 1000000 * SYNC_PERIOD_US;
endpackage

// [core/fbs_slave.sv]
// Purpose: Drive end: communication states, addressing, mapping, process data, overspeed
// Assumes: Master and neighbour links run on mclk
// Notes:   Parameters reached by SDO frames only
// Behaviour
// R1: Overspeed raises fault and stops motor
// R2: Zero threshold means 1.2 times max speed
// R3: Torque mode switches to velocity-limited control
// R4: Source selects master-assigned or stored address
// R5: Station number 0..32767, applied after restart
// R6: Read, insert, forward frames with register delay
// R7: Last slave loops frame back to master
// R8: Free-run applies received process data immediately
// R9: Distributed clock stages data, applies at sync
// R10: Master delivers process data before sync event
// R11: Upward transitions one step at a time
// R12: Downward transitions may skip states
// R13: Failed transition reports error to master
// R14: Init blocks mailbox and process data
// R15: Pre-operational allows mailbox, blocks process data
// R16: Safe-operational transmits but ignores received data
// R17: Operational exchanges both process data directions
// R18: Mailbox SDO carries full 32-bit payload
// R19: Sync mode sets process data update rate
// R20: Two receive and two transmit sets
// R21: At most 8 entries, 32 bytes per object
// R22: Entry holds index, subindex, bit length
// R23: Mapping writable in pre-op, active from safe-op
// R24: Oversized mapping refused, previous kept, error
`timescale 1ns/1ps
module fbs_slave (
   input  wire logic            mclk,
   input  wire logic            reset,
   fbs_link_if.slave            link,
   output fbs_pkg::fbs_frame_s  dn_frm,
   output logic                 dn_valid,
   input  wire logic            dn_open,
   input  wire fbs_pkg::fbs_frame_s ret_frm,
   input  wire logic            ret_valid,
   input  wire logic            restart,
   input  wire logic [15:0]     motor_speed,
   input  wire logic [15:0]     max_speed,
   input  wire logic            torque_mode,
   input  wire logic [15:0]     vel_limit,
   input  wire logic            fault_clear,
   output logic                 overspeed_fault,
   output logic                 motor_stop,
   output logic                 speed_limit_active,
   output fbs_pkg::fbs_state_e  comm_state,
   output logic [1:0]           rx_apply,
   output logic [31:0]          rx_data0,
   output logic [31:0]          rx_data1,
   input  wire logic [31:0]     tx_data0,
   input  wire logic [31:0]     tx_data1,
   output logic [15:0]          station_addr
);
   import fbs_pkg::*;
   function automatic logic [2:0] map_sel(input logic [15:0] idx);
      if (idx == IDX_RXMAP0) map_sel = 3'h4;
      else if (idx == IDX_RXMAP1) map_sel = 3'h5;
      else if (idx == IDX_TXMAP0) map_sel = 3'h6;
      else if (idx == IDX_TXMAP1) map_sel = 3'h7;
      else map_sel = 3'h0;
   endfunction
   function automatic logic map_ok(input logic [3:0] cnt, input logic [7:0][31:0] ent);
      logic [8:0] sum;
      sum = '0;
      for (int i = 0; i < 8; i++) begin
         if (4'(i) < cnt) sum = sum + {1'b0, ent[i][MAP_LEN_LSB +: 8]};
      end
      map_ok = (cnt <= MAP_MAX_ENT) && (sum <= MAP_MAX_BITS);
   endfunction
   fbs_state_e       st_q;
   logic [15:0]      stn_val_q;
   logic [15:0]      stn_src_q;
   logic [15:0]      src_eff_q;
   logic [15:0]      addr_q;
   logic [15:0]      ovs_q;
   logic             dc_q;
   logic [7:0][31:0] pend_q [4];
   logic [3:0]       pcnt_q [4];
   logic [3:0]       acnt_q [4];
   logic [31:0]      txs_q [PDO_SETS];
   logic [31:0]      stage_q [PDO_SETS];
   logic [1:0]       stv_q;
   logic             out_valid_q;
   fbs_frame_s       out_q;
   fbs_frame_s       f;
   fbs_frame_s       fw;
   logic             hit;
   logic             err;
   logic             go;
   logic             commit;
   logic             wr;
   logic [2:0]       ms;
   logic [1:0]       cur_n;
   logic [1:0]       tgt_n;
   logic             all_ok;
   logic             push;
   logic             f_in_ready;
   logic             f_out_valid;
   logic             f_out_ready;
   logic [32:0]      f_out;
   logic [3:0]       e_sub;
   assign f     = link.m2s_frm;
   assign hit   = link.m2s_valid && f.cmd != CMD_ASSIGN && f.adr == addr_q;
   assign ms    = map_sel(f.idx);
   assign cur_n = st_q;
   assign tgt_n = f.data[1:0];
   assign e_sub = f.sub[3:0] - 4'h1;
   assign all_ok = map_ok(pcnt_q[0], pend_q[0]) && map_ok(pcnt_q[1], pend_q[1]) &&
                   map_ok(pcnt_q[2], pend_q[2]) && map_ok(pcnt_q[3], pend_q[3]);
   always_comb begin
      fw = f;
      err = 1'b0;
      go = 1'b0;
      commit = 1'b0;
      wr = 1'b0;
      push = 1'b0;
      case (f.cmd)
         CMD_STATE: begin
            if (tgt_n > cur_n && tgt_n != cur_n + 2'h1) err = 1'b1; // [R11] [R13]
            else if (tgt_n > cur_n && cur_n == FBS_PREOP && !all_ok) err = 1'b1; // [R24] [R13]
            else begin
               go = 1'b1; // [R12]
               commit = tgt_n > cur_n && cur_n == FBS_PREOP; // [R23]
            end
         end
         CMD_SDO_WR, CMD_SDO_RD: begin
            wr = f.cmd == CMD_SDO_WR;
            if (st_q == FBS_INIT) err = 1'b1; // [R14]
            else if (f.idx == IDX_STN_VAL) begin
               fw.data = {16'h0000, stn_val_q};
               err = wr && f.data[15:0] > STN_VAL_MAX; // [R5]
            end else if (f.idx == IDX_STN_SRC) begin
               fw.data = {16'h0000, stn_src_q};
               err = wr && f.data[15:0] > STN_SRC_MAX; // [R4]
            end else if (f.idx == IDX_OVSPD) begin
               fw.data = {16'h0000, ovs_q};
               err = wr && f.data[15:0] > OVSPD_MAX; // [R1]
            end else if (f.idx == IDX_SYNC_MODE) begin
               fw.data = {31'h00000000, dc_q};
            end else if (ms[2]) begin
               fw.data = (f.sub == 8'h00) ? {28'h0000000, pcnt_q[ms[1:0]]} : pend_q[ms[1:0]][e_sub[2:0]];
               if (wr && st_q != FBS_PREOP) err = 1'b1; // [R23]
               else if (f.sub > 8'h08) err = 1'b1; // [R21]
               else if (wr && f.sub == 8'h00 && f.data > 32'h00000008) err = 1'b1; // [R24]
            end else err = 1'b1;
            if (!wr) fw.data = err ? 32'h00000000 : fw.data; // [R18]
         end
         CMD_RXPDO: begin
            if (st_q != FBS_OP) err = 1'b1; // [R15] [R16] [R17]
            else if (acnt_q[{1'b0, f.sub[0]}] == 4'h0) err = 1'b1; // [R20]
            else if (!f_in_ready) err = 1'b1;
            else push = hit;
         end
         CMD_TXPDO: begin
            if (st_q == FBS_INIT || st_q == FBS_PREOP) err = 1'b1; // [R15]
            else if (acnt_q[{1'b1, f.sub[0]}] == 4'h0) err = 1'b1; // [R20]
            else fw.data = dc_q ? txs_q[f.sub[0]] : (f.sub[0] ? tx_data1 : tx_data0); // [R16] [R17] [R19]
         end
         default: err = 1'b0;
      endcase
      if (hit) begin
         fw.err = f.err | err; // [R13]
         fw.wkc = 1'b1;
      end else fw = f;
      if (f.cmd == CMD_ASSIGN) begin
         fw.adr = f.adr - 16'h0001;
         fw.wkc = f.wkc | (f.adr == 16'h0000 && src_eff_q == 16'h0000);
      end
   end
   always_ff @(posedge mclk) begin
      if (reset) st_q <= FBS_INIT;
      else if (hit && go) st_q <= fbs_state_e'(tgt_n);
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         stn_val_q <= RST_STN_VAL;
         stn_src_q <= RST_STN_SRC;
         ovs_q     <= RST_OVSPD;
         dc_q      <= 1'b0;
      end else if (hit && wr && !err) begin
         if (f.idx == IDX_STN_VAL) stn_val_q <= f.data[15:0];
         if (f.idx == IDX_STN_SRC) stn_src_q <= f.data[15:0];
         if (f.idx == IDX_OVSPD) ovs_q <= f.data[15:0];
         if (f.idx == IDX_SYNC_MODE) dc_q <= f.data[0];
      end
   end
   // Address parameters only take hold at reset or restart; an assign frame sets the address mid-session when src_eff_q is 0
   always_ff @(posedge mclk) begin
      if (reset) begin
         src_eff_q <= RST_STN_SRC;
         addr_q    <= RST_STN_VAL;
      end else if (restart) begin
         src_eff_q <= stn_src_q; // [R5]
         addr_q    <= stn_src_q == 16'h0000 ? 16'h0000 : stn_val_q; // [R4]
      end else if (link.m2s_valid && f.cmd == CMD_ASSIGN && f.adr == 16'h0000 && src_eff_q == 16'h0000) begin
         addr_q <= f.data[15:0]; // [R4]
      end
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         for (int i = 0; i < 4; i++) begin
            pcnt_q[i] <= 4'h0;
            acnt_q[i] <= 4'h0;
            pend_q[i] <= '0;
         end
      end else begin
         if (hit && wr && !err && ms[2]) begin
            if (f.sub == 8'h00) pcnt_q[ms[1:0]] <= f.data[3:0];
            else pend_q[ms[1:0]][e_sub[2:0]] <= f.data; // [R22]
         end
         if (hit && commit) begin
            for (int i = 0; i < 4; i++) acnt_q[i] <= pcnt_q[i]; // [R23]
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         for (int i = 0; i < PDO_SETS; i++) txs_q[i] <= 32'h00000000;
      end else if (link.sync0) begin
         txs_q[0] <= tx_data0; // [R19]
         txs_q[1] <= tx_data1;
      end
   end
   fbs_fifo #(
      .W (33),
      .D (RX_FIFO_DEPTH)
   ) u_rx_fifo (
      .mclk      (mclk),
      .reset     (reset),
      .in_valid  (push),
      .in_ready  (f_in_ready),
      .in_data   ({f.sub[0], f.data}),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out)
   );
   // In sync mode a set stalls the buffer until its staged word has been applied
   assign f_out_ready = !dc_q || !stv_q[f_out[32]]; // [R9]
   always_ff @(posedge mclk) begin
      if (reset) begin
         stv_q    <= 2'h0;
         rx_apply <= 2'h0;
         rx_data0 <= 32'h00000000;
         rx_data1 <= 32'h00000000;
         for (int i = 0; i < PDO_SETS; i++) stage_q[i] <= 32'h00000000;
      end else begin
         rx_apply <= 2'h0;
         if (dc_q && link.sync0) begin
            rx_apply <= stv_q; // [R9]
            if (stv_q[0]) rx_data0 <= stage_q[0];
            if (stv_q[1]) rx_data1 <= stage_q[1];
            stv_q <= 2'h0;
         end else if (f_out_valid && f_out_ready && dc_q) begin
            stage_q[f_out[32]] <= f_out[31:0]; // [R9]
            stv_q[f_out[32]]   <= 1'b1;
         end else if (f_out_valid && !dc_q) begin
            rx_apply[f_out[32]] <= 1'b1; // [R8]
            if (f_out[32]) rx_data1 <= f_out[31:0];
            else rx_data0 <= f_out[31:0];
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         out_valid_q <= 1'b0;
         out_q       <= '0;
      end else begin
         out_valid_q <= link.m2s_valid; // [R6]
         out_q       <= fw;
      end
   end
   assign dn_valid = out_valid_q && !dn_open; // [R6]
   assign dn_frm   = out_q;
   assign link.s2m_valid = dn_open ? out_valid_q : ret_valid; // [R7]
   assign link.s2m_frm   = dn_open ? out_q : ret_frm;
   logic [18:0] lvl;
   assign lvl = (ovs_q == 16'h0000) ? ({3'h0, max_speed} * OVS_NUM) / OVS_DEN : {3'h0, ovs_q}; // [R2]
   always_ff @(posedge mclk) begin
      if (reset) overspeed_fault <= 1'b0;
      else if ({3'h0, motor_speed} > lvl) overspeed_fault <= 1'b1; // [R1]
      else if (fault_clear) overspeed_fault <= 1'b0;
   end
   assign motor_stop         = overspeed_fault; // [R1]
   assign speed_limit_active = torque_mode && motor_speed >= vel_limit; // [R3]
   assign comm_state         = st_q;
   assign station_addr       = addr_q;
endmodule

// [test/fbs_link_properties.sv]
// Purpose: Link checks between bus master and drive slave
// Assumes: One drive at address 2, open downstream port
// Notes:   State is tracked from acknowledged state frames
`timescale 1ns/1ps
module fbs_link_properties (
   input wire logic               mclk,
   input wire logic               reset,
   input wire logic               m2s_valid,
   input wire fbs_pkg::fbs_frame_s m2s_frm,
   input wire logic               s2m_valid,
   input wire fbs_pkg::fbs_frame_s s2m_frm,
   input wire logic               sync0
);
   import fbs_pkg::*;
   fbs_state_e st_q;
   logic [1:0] tgt_q;
   logic       hit;
   logic       mbx;
   logic       pdo;
   assign hit = m2s_valid && m2s_frm.adr == 16'h0002;
   assign mbx = m2s_frm.cmd inside {CMD_SDO_WR, CMD_SDO_RD};
   assign pdo = m2s_frm.cmd inside {CMD_RXPDO, CMD_TXPDO};
   always_ff @(posedge mclk) begin
      if (reset) tgt_q <= 2'h0;
      else if (m2s_valid) tgt_q <= m2s_frm.data[1:0];
   end
   // Only acknowledged state frames move the tracked state
   always_ff @(posedge mclk) begin
      if (reset) st_q <= FBS_INIT;
      else if (s2m_valid && s2m_frm.cmd == CMD_STATE && s2m_frm.wkc && !s2m_frm.err) st_q <= fbs_state_e'(tgt_q);
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   AST_REPLY: assert property (m2s_valid |=> s2m_valid && s2m_frm.cmd == $past(m2s_frm.cmd))
      else $error("no return frame");
   AST_NO_SPONT: assert property (s2m_valid |-> $past(m2s_valid))
      else $error("slave sent on its own");
   AST_FWD: assert property (m2s_valid && m2s_frm.adr != 16'h0002 && m2s_frm.cmd != CMD_ASSIGN
      |=> s2m_frm == $past(m2s_frm)) else $error("foreign frame altered");
   AST_SYNC_SEP: assert property (sync0 |-> !m2s_valid && !s2m_valid)
      else $error("sync during frame");
   AST_STEP: assert property (m2s_valid && m2s_frm.cmd == CMD_STATE && m2s_frm.data[1:0] > st_q
      |-> m2s_frm.data[1:0] == st_q + 2'h1) else $error("state step skipped");
   AST_INIT_BLOCK: assert property (hit && (mbx || pdo) && st_q == FBS_INIT |=> s2m_frm.err)
      else $error("traffic in init");
   AST_PREOP_PDO: assert property (hit && pdo && st_q == FBS_PREOP |=> s2m_frm.err)
      else $error("process data in preop");
   AST_SAFEOP_RX: assert property (hit && m2s_frm.cmd == CMD_RXPDO && st_q == FBS_SAFEOP |=> s2m_frm.err)
      else $error("rx data in safeop");
   AST_DOWN: assert property (hit && m2s_frm.cmd == CMD_STATE && m2s_frm.data[1:0] < st_q
      |=> s2m_frm.wkc && !s2m_frm.err) else $error("downward step refused");
endmodule

// [test/fieldbus_slave_comm_state_pdo_bench.sv]
// Purpose: Bench for master and drive joined by the frame link
// Assumes: One drive, open downstream port, sync period cut to 50
// Notes:   All requests go through the master command port
`timescale 1ns/1ps
module fieldbus_slave_comm_state_pdo_bench;
   import fbs_pkg::*;
   logic        mclk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, dc_enable = 1'b0, restart = 1'b0;
   logic        cmd_ready, rsp_valid, torque_mode = 1'b1, fault_clear = 1'b0;
   logic        overspeed_fault, motor_stop, speed_limit_active;
   logic [1:0]  rx_apply;
   logic [15:0] spd = 16'h0, station_addr, dst = 16'h0002, max_speed = 16'd1000;
   logic [31:0] rx_data0, rx_data1, tx_data0 = 32'h1234abcd, tx_data1 = 32'h0;
   fbs_frame_s  cmd_frm = '0, rsp_frm, r;
   fbs_state_e  cur_state, comm_state;
   int          miscompares = 0, samples_checked = 0, i, j;
   logic [15:0] idx_t [3] = '{IDX_STN_VAL, IDX_STN_SRC, IDX_OVSPD};
   logic [15:0] rst_t [3] = '{RST_STN_VAL, RST_STN_SRC, RST_OVSPD};
   logic [15:0] bad_t [3] = '{16'h8000, 16'h0002, 16'h2711};
   fbs_link_if link ();
   fbs_master #(.SYNC_CYCLES(50)) fbs_master_inst (.mclk, .reset, .link, .cmd_valid, .cmd_ready, .cmd_frm,
      .rsp_valid, .rsp_frm, .dc_enable, .cur_state);
   fbs_slave fbs_slave_inst (.mclk, .reset, .link, .dn_frm(), .dn_valid(), .dn_open(1'b1), .ret_frm('0),
      .ret_valid(1'b0), .restart, .motor_speed(spd), .max_speed, .torque_mode, .vel_limit(16'd500), .fault_clear,
      .overspeed_fault, .motor_stop, .speed_limit_active, .comm_state, .rx_apply, .rx_data0, .rx_data1, .tx_data0,
      .tx_data1, .station_addr);
   fbs_link_properties fbs_link_properties_inst (.mclk, .reset, .m2s_valid(link.m2s_valid), .m2s_frm(link.m2s_frm),
      .s2m_valid(link.s2m_valid), .s2m_frm(link.s2m_frm), .sync0(link.sync0));
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic guard(input logic ok);
      if (!ok) begin
         miscompares++;
         $display("CHECK FAILED at %0t: handshake timed out", $time);
         report_and_stop();
      end
   endtask
   // Held from a falling edge until taken
   task automatic xfer(input fbs_cmd_e c, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
      int n;
      cmd_frm = '{c, dst, idx, sub, d, 1'b0, 1'b0};
      cmd_valid = 1'b1;
      for (n = 0; n < 200 && cmd_ready !== 1'b1; n++) @(negedge mclk);
      guard(cmd_ready === 1'b1);
      @(negedge mclk);
      cmd_valid = 1'b0;
      for (n = 0; n < 200 && rsp_valid !== 1'b1; n++) @(negedge mclk);
      guard(rsp_valid === 1'b1);
      r = rsp_frm;
   endtask
   // Clear fault so each probe starts clean
   task automatic spin(input logic [15:0] s, input logic e);
      spd = s;
      repeat (3) @(negedge mclk);
      chk({overspeed_fault, motor_stop}, {e, e}, "overspeed");
      spd = 16'h0;
      fault_clear = 1'b1;
      repeat (2) @(negedge mclk);
      fault_clear = 1'b0;
   endtask
   initial begin
      repeat (10) @(negedge mclk);
      reset = 1'b0;
      @(negedge mclk);
      chk({comm_state, station_addr}, {FBS_INIT, 16'h0002}, "reset state");
      xfer(CMD_SDO_RD, IDX_STN_VAL, 8'h00, 32'h0);
      chk(r.err, 1'b1, "init mailbox");
      dst = 16'h0003;
      xfer(CMD_SDO_RD, IDX_STN_VAL, 8'h00, 32'h0);
      chk({r.err, r.wkc}, 2'b00, "foreign frame");
      dst = 16'h0002;
      xfer(CMD_STATE, 16'h0, 8'h0, 32'h1);
      chk(comm_state, FBS_PREOP, "preop");
      for (i = 0; i < 3; i++) begin
         xfer(CMD_SDO_RD, idx_t[i], 8'h00, 32'h0);
         chk(r.data, {16'h0, rst_t[i]}, "reset value");
         xfer(CMD_SDO_WR, idx_t[i], 8'h00, {16'h0, bad_t[i]});
         chk(r.err, 1'b1, "out of range");
      end
      xfer(CMD_SDO_WR, IDX_OVSPD, 8'h00, 32'd100);
      spin(16'd100, 1'b0);
      spin(16'd101, 1'b1);
      xfer(CMD_SDO_WR, IDX_OVSPD, 8'h00, 32'h0);
      spin(16'd1200, 1'b0);
      spin(16'd1201, 1'b1);
      for (i = 0; i < 2; i++) begin
         spd = 16'd499 + 16'(i);
         #1 chk(speed_limit_active, i[0], "velocity limit");
         xfer(i[0] ? CMD_TXPDO : CMD_RXPDO, 16'h0, 8'h0, 32'h0);
         chk(r.err, 1'b1, "preop process data");
      end
      xfer(CMD_SDO_WR, IDX_RXMAP0, 8'h01, 32'h60400080);
      xfer(CMD_SDO_WR, IDX_RXMAP0, 8'h02, 32'h60ff0088);
      xfer(CMD_SDO_WR, IDX_RXMAP0, 8'h00, 32'h2);
      xfer(CMD_SDO_WR, IDX_RXMAP1, 8'h01, 32'h60ff0020);
      xfer(CMD_SDO_WR, IDX_RXMAP1, 8'h00, 32'h1);
      xfer(CMD_SDO_WR, IDX_TXMAP0, 8'h01, 32'h60410020);
      xfer(CMD_SDO_WR, IDX_TXMAP0, 8'h00, 32'h1);
      xfer(CMD_SDO_WR, IDX_RXMAP0, 8'h00, 32'h9);
      chk(r.err, 1'b1, "entry count");
      xfer(CMD_STATE, 16'h0, 8'h0, 32'h2);
      chk({r.err, comm_state}, {1'b1, FBS_PREOP}, "oversized map");
      xfer(CMD_SDO_WR, IDX_RXMAP0, 8'h02, 32'h60ff0020);
      xfer(CMD_SDO_RD, IDX_RXMAP0, 8'h02, 32'h0);
      chk(r.data, 32'h60ff0020, "map entry");
      xfer(CMD_STATE, 16'h0, 8'h0, 32'h2);
      chk({r.err, comm_state}, {1'b0, FBS_SAFEOP}, "safeop");
      xfer(CMD_TXPDO, 16'h0, 8'h0, 32'h0);
      chk({r.err, r.data}, {1'b0, tx_data0}, "tx data");
      xfer(CMD_RXPDO, 16'h0, 8'h0, 32'h0);
      chk(r.err, 1'b1, "safeop rx");
      xfer(CMD_SDO_WR, IDX_RXMAP0, 8'h00, 32'h1);
      chk(r.err, 1'b1, "late map write");
      xfer(CMD_STATE, 16'h0, 8'h0, 32'h3);
      for (i = 0; i < 2; i++) begin
         xfer(CMD_RXPDO, 16'h0, i[7:0], 32'hc0de0000 + i);
         repeat (5) @(negedge mclk);
         chk(i[0] ? rx_data1 : rx_data0, 32'hc0de0000 + i, "free-run rx");
      end
      xfer(CMD_STATE, 16'h0, 8'h0, 32'h1);
      chk(comm_state, FBS_PREOP, "skip down");
      xfer(CMD_SDO_WR, IDX_SYNC_MODE, 8'h00, 32'h1);
      xfer(CMD_STATE, 16'h0, 8'h0, 32'h3);
      chk({r.err, comm_state}, {1'b0, FBS_OP}, "stepped up");
      dc_enable = 1'b1;
      xfer(CMD_RXPDO, 16'h0, 8'h0, 32'h5a5a0001);
      chk(rx_data0, 32'hc0de0000, "staged");
      for (j = 0; j < 200 && link.sync0 !== 1'b1; j++) @(negedge mclk);
      guard(link.sync0 === 1'b1);
      @(negedge mclk);
      chk({rx_apply[0], rx_data0}, {1'b1, 32'h5a5a0001}, "sync apply");
      dc_enable = 1'b0;
      xfer(CMD_STATE, 16'h0, 8'h0, 32'h0);
      chk(comm_state, FBS_INIT, "op to init");
      xfer(CMD_STATE, 16'h0, 8'h0, 32'h1);
      xfer(CMD_SDO_WR, IDX_STN_VAL, 8'h00, 32'h7);
      chk(station_addr, 16'h0002, "before restart");
      restart = 1'b1;
      @(negedge mclk);
      restart = 1'b0;
      @(negedge mclk);
      chk(station_addr, 16'h0007, "after restart");
      report_and_stop();
   end
endmodule
